//--- timer_cc_pkg.sv
package timer_cc_pkg;
  // Overview of operation
  // RL1: Master trigger source code 001 drives the counter enable out as trigger.
  // RL2: Sync bit makes the timer slave and master at once, starting both together.
  // RL3: Trigger select 100 takes the master timer trigger output as trigger input.
  // RL4: Trigger slave mode starts the counter on an active edge and sets trigger flag.
  // RL5: Direction zero means output compare with free access; nonzero means input.
  // RL6: Bus reaches preload only; capture fills shadow then preload; compare copies back.
  // RL7: Input mode value is read-only; preload freezes during a two-byte read.
  // RL8: Output mode writes high byte first; shadow update waits for the low byte.
  // RL9: Pin is sampled, filtered, edge detected with polarity, prescaled to capture.
  // RL10: A capture edge latches the counter, sets capture flag, may raise interrupt.
  // RL11: A capture while the capture flag is set also sets overcapture.
  // RL12: Capture flag clears on zero write or low byte read; overcapture on zero write.
  // RL13: Filter code 0011 accepts a level after eight identical samples.
  // RL14: Polarity zero captures rising edges, one captures falling edges.
  // RL15: Prescaler code zero captures on every accepted edge.
  // RL16: Pin edges capture counter values only while the channel enable bit is set; a software event captures regardless, but in input mode only.
  // RL17: Direction 01 uses own input; 10 uses the neighbouring channel input.
  // RL18: Reset slave mode clears the counter on the selected filtered edge.
  // RL19: A software event bit produces a capture event and its interrupt.
  // RL20: Compare mode 101 forces reference high, 100 low; pin follows polarity.
  // RL21: Forced outputs still compare, set match flags and raise interrupts.
  // RL22: Reference is active high; polarity applies only at the final pin stage.
  // RL23: Captures during a frozen read reach shadow, then preload after the read.
  localparam logic [7:0]  OFS_CTRL           = 8'h00;
  localparam logic [7:0]  OFS_STATUS         = 8'h04;
  localparam logic [7:0]  OFS_IRQ_EN         = 8'h08;
  localparam logic [7:0]  OFS_EVENT          = 8'h0C;
  localparam logic [7:0]  OFS_COUNT          = 8'h28;
  localparam logic [7:0]  OFS_CH_MODE [2]    = '{8'h10, 8'h14};
  localparam logic [7:0]  OFS_VAL_HI [2]     = '{8'h18, 8'h20};
  localparam logic [7:0]  OFS_VAL_LO [2]     = '{8'h1C, 8'h24};
  localparam logic [2:0]  MMS_ENABLE         = 3'h1;
  localparam logic [2:0]  MMS_OC1REF         = 3'h4;
  localparam logic [2:0]  SMS_RESET          = 3'h4;
  localparam logic [2:0]  SMS_TRIGGER        = 3'h6;
  localparam logic [2:0]  TS_INTERNAL        = 3'h4;
  localparam logic [2:0]  TS_FP1             = 3'h5;
  localparam logic [2:0]  TS_FP2             = 3'h6;
  localparam logic [2:0]  OCM_FORCE_LOW      = 3'h4;
  localparam logic [2:0]  OCM_FORCE_HIGH     = 3'h5;
  localparam logic [1:0]  DIR_OUTPUT         = 2'h0;
  localparam logic [1:0]  DIR_NEIGHBOUR      = 2'h2;
  localparam logic [3:0]  FILT_8             = 4'h3;
  localparam logic [2:0]  CNT3_ZERO          = 3'h0;
  localparam logic [2:0]  CNT3_ONE           = 3'h1;
  localparam logic [2:0]  CNT3_MAX           = 3'h7;
  localparam logic [15:0] CNT_RST            = 16'h0000;
  localparam logic [15:0] CNT_STEP           = 16'h0001;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        pwrite;
    logic [31:0] pwdata;
    logic        psel;
    logic        penable;
  } apb_req_s;

  typedef struct packed {
    logic       master_slave_sync_bit;
    logic [2:0] trigger_input_select;
    logic [2:0] slave_mode_select;
    logic [2:0] master_trigger_source_select;
    logic       counter_enable_signal;
  } ctrl_s;

  typedef struct packed {
    logic [2:0] output_compare_mode;
    logic       channel_enable_bit;
    logic       channel_polarity;
    logic [1:0] input_prescaler_setting;
    logic [3:0] input_filter_setting;
    logic [1:0] channel_direction_select;
  } ch_cfg_s;

  typedef struct packed {
    logic [1:0] channel_overcapture_flag;
    logic [1:0] channel_capture_flag;
    logic       trigger_flag;
  } status_s;

  typedef struct packed {
    logic [1:0] channel_sw_event;
    logic       update_generation;
  } event_s;

  localparam ctrl_s   CTRL_RST = '0;
  localparam ch_cfg_s CFG_RST  = '0;
  localparam status_s STAT_RST = '0;
  localparam event_s  EVT_NONE = '0;

  function automatic logic [2:0] psc_limit(input logic [1:0] code);
    psc_limit = 3'((4'h1 << code) - 4'h1);
  endfunction : psc_limit

  function automatic logic [2:0] filt_limit(input logic [3:0] code);
    filt_limit = (code > FILT_8) ? CNT3_MAX : psc_limit(code[1:0]);
  endfunction : filt_limit
endpackage : timer_cc_pkg

//--- timer_cc_channels.sv
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
module timer_cc_channels (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire timer_cc_pkg::apb_req_s apb_req,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [1:0]             timer_input,
  input  wire logic                   trigger_in,
  output logic                        trigger_out,
  output logic                        irq_request,
  output logic [1:0]                  compare_reference_signal,
  output logic [1:0]                  compare_out
);
  import timer_cc_pkg::*;

  ctrl_s       ctrl_q;
  ctrl_s       ctrl_d;
  ctrl_s       ctrl_wr;
  ch_cfg_s     cfg_q [2];
  status_s     stat_q;
  status_s     stat_d;
  status_s     stat_set;
  status_s     stat_clr;
  event_s      evt;
  logic [1:0]  irq_en_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [31:0] prdata_q;
  logic [31:0] rdata;
  logic        pready_q;
  logic        pslverr_q;
  logic        trig_out_q;
  logic        trig_out_d;
  logic        irq_q;
  logic        trg_prev_q;
  logic        trg_evt_q;
  logic [1:0]  s1_q;
  logic [1:0]  s2_q;
  logic [1:0]  filt_q;
  logic [1:0]  lvl_q;
  logic [1:0]  ref_q;
  logic [1:0]  out_q;
  logic [1:0]  hold_q;
  logic [1:0]  frz_q;
  logic [2:0]  fcnt_q [2];
  logic [2:0]  pcnt_q [2];
  logic [15:0] pre_q [2];
  logic [15:0] shd_q [2];
  logic [1:0]  in_mode;
  logic [1:0]  fp;
  logic [1:0]  lvl;
  logic [1:0]  edg;
  logic [1:0]  psc_hit;
  logic [1:0]  cap_evt;
  logic [1:0]  latch;
  logic [1:0]  match;
  logic [1:0]  flag_set;
  logic [1:0]  ovr_set;
  logic [1:0]  ref_d;
  logic [1:0]  out_d;
  logic [1:0]  wr_hi;
  logic [1:0]  wr_lo;
  logic [1:0]  rd_lo;
  logic [1:0]  rd_hi_on;
  logic [1:0]  wr_cfg;
  logic [7:0]  addr;
  logic [7:0]  wbyte;
  logic        req;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_ien;
  logic        wr_evt;
  logic        wr_cnt;
  logic        trg_lvl;
  logic        trg_edge;
  logic        trg_evt;
  logic        trg_eff;
  logic        start_now;
  logic        start;
  logic        clr_cnt;
  logic        irq_d;
  logic [2:0]  master_trigger_source_select;
  logic [2:0]  slave_mode_select;
  logic [2:0]  trigger_input_select;
  logic        master_slave_sync_bit;
  logic        counter_enable_signal;

  // Bus decode. A transfer takes effect at the edge where pready is high.
  assign addr    = apb_req.paddr;
  assign wbyte   = apb_req.pwdata[7:0];
  assign req     = apb_req.psel & apb_req.penable;
  assign acc     = req & pready_q;
  assign wr      = acc & apb_req.pwrite;
  assign rd      = acc & ~apb_req.pwrite;
  assign wr_ctrl = wr & (addr == OFS_CTRL);
  assign wr_stat = wr & (addr == OFS_STATUS);
  assign wr_ien  = wr & (addr == OFS_IRQ_EN);
  assign wr_evt  = wr & (addr == OFS_EVENT);
  assign wr_cnt  = wr & (addr == OFS_COUNT);
  assign mapped  = addr inside {OFS_CTRL, OFS_STATUS, OFS_IRQ_EN, OFS_EVENT, OFS_COUNT,
                                OFS_CH_MODE[0], OFS_CH_MODE[1], OFS_VAL_HI[0],
                                OFS_VAL_HI[1], OFS_VAL_LO[0], OFS_VAL_LO[1]};
  assign ctrl_wr = ctrl_s'(apb_req.pwdata[$bits(ctrl_s)-1:0]);
  assign evt     = wr_evt ? event_s'(apb_req.pwdata[$bits(event_s)-1:0]) : EVT_NONE;

  assign master_trigger_source_select = ctrl_q.master_trigger_source_select;
  assign slave_mode_select            = ctrl_q.slave_mode_select;
  assign trigger_input_select         = ctrl_q.trigger_input_select;
  assign master_slave_sync_bit        = ctrl_q.master_slave_sync_bit;
  assign counter_enable_signal        = ctrl_q.counter_enable_signal;

  // Trigger controller.
  assign trg_lvl   = (trigger_input_select == TS_INTERNAL) ? trigger_in : // RL3
                     (trigger_input_select == TS_FP1) ? fp[0] :
                     (trigger_input_select == TS_FP2) ? fp[1] : 1'h0;
  assign trg_edge  = trg_lvl & ~trg_prev_q;
  assign trg_evt   = trg_edge & ((slave_mode_select == SMS_RESET) |
                                 (slave_mode_select == SMS_TRIGGER));
  assign trg_eff   = master_slave_sync_bit ? trg_evt_q : trg_evt; // RL2
  assign start_now = trg_evt & (slave_mode_select == SMS_TRIGGER);
  assign start     = trg_eff & (slave_mode_select == SMS_TRIGGER); // RL4
  assign clr_cnt   = trg_eff & (slave_mode_select == SMS_RESET); // RL18

  always_comb begin
    ctrl_d = wr_ctrl ? ctrl_wr : ctrl_q;
    ctrl_d.counter_enable_signal = start | ctrl_d.counter_enable_signal; // RL4
  end

  assign trig_out_d = (master_trigger_source_select == MMS_ENABLE) ? // RL1
                      (ctrl_d.counter_enable_signal | start_now) :
                      (master_trigger_source_select == MMS_OC1REF) ? ref_d[0] : 1'h0;

  assign cnt_d = (evt.update_generation | clr_cnt) ? CNT_RST : // RL18
                 wr_cnt ? apb_req.pwdata[15:0] :
                 counter_enable_signal ? cnt_q + CNT_STEP : cnt_q;

  // Status flags. A hardware set wins over a clear in the same cycle.
  assign stat_set = {ovr_set, flag_set, trg_evt}; // RL4
  assign stat_clr = ({$bits(status_s){wr_stat}} & ~apb_req.pwdata[$bits(status_s)-1:0]) |
                    {2'h0, rd_lo & in_mode, 1'h0}; // RL12
  assign stat_d   = stat_set | (stat_q & ~stat_clr);
  assign irq_d    = |(stat_d.channel_capture_flag & irq_en_q); // RL10

  always_comb begin
    rdata = 32'h0;
    case (addr)
      OFS_CTRL:       rdata = 32'(ctrl_q);
      OFS_STATUS:     rdata = 32'(stat_q);
      OFS_IRQ_EN:     rdata = 32'(irq_en_q);
      OFS_COUNT:      rdata = 32'(cnt_q);
      OFS_CH_MODE[0]: rdata = 32'(cfg_q[0]);
      OFS_CH_MODE[1]: rdata = 32'(cfg_q[1]);
      OFS_VAL_HI[0]:  rdata = 32'(pre_q[0][15:8]); // RL6
      OFS_VAL_HI[1]:  rdata = 32'(pre_q[1][15:8]);
      OFS_VAL_LO[0]:  rdata = 32'(pre_q[0][7:0]);
      OFS_VAL_LO[1]:  rdata = 32'(pre_q[1][7:0]);
      default:        rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pready_q  <= 1'h0;
      pslverr_q <= 1'h0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= req & ~pready_q;
      pslverr_q <= req & ~pready_q & ~mapped;
      if (req & ~pready_q) begin
        prdata_q <= rdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl_q     <= CTRL_RST;
      stat_q     <= STAT_RST;
      irq_en_q   <= 2'h0;
      cnt_q      <= CNT_RST;
      trg_prev_q <= 1'h0;
      trg_evt_q  <= 1'h0;
      trig_out_q <= 1'h0;
      irq_q      <= 1'h0;
    end else begin
      ctrl_q     <= ctrl_d;
      stat_q     <= stat_d;
      cnt_q      <= cnt_d;
      trg_prev_q <= trg_lvl;
      trg_evt_q  <= trg_evt;
      trig_out_q <= trig_out_d;
      irq_q      <= irq_d;
      if (wr_ien) begin
        irq_en_q <= apb_req.pwdata[1:0];
      end
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_ch
    localparam int OTHER = 1 - i;
    assign in_mode[i]  = cfg_q[i].channel_direction_select != DIR_OUTPUT; // RL5
    assign fp[i]       = filt_q[i] ^ cfg_q[i].channel_polarity; // RL9
    assign lvl[i]      = (cfg_q[i].channel_direction_select == DIR_NEIGHBOUR) ? // RL17
                         filt_q[OTHER] : filt_q[i];
    assign edg[i]      = (lvl[i] ^ cfg_q[i].channel_polarity) & // RL14
                         ~(lvl_q[i] ^ cfg_q[i].channel_polarity);
    assign psc_hit[i]  = pcnt_q[i] == psc_limit(cfg_q[i].input_prescaler_setting); // RL15
    assign cap_evt[i]  = (in_mode[i] & cfg_q[i].channel_enable_bit & edg[i] & psc_hit[i]) | // RL16
                         evt.channel_sw_event[i]; // RL19
    assign latch[i]    = cap_evt[i] & in_mode[i]; // RL10
    assign match[i]    = ~in_mode[i] & counter_enable_signal & (cnt_q == shd_q[i]); // RL21
    assign flag_set[i] = cap_evt[i] | match[i];
    assign ovr_set[i]  = latch[i] & stat_q.channel_capture_flag[i]; // RL11
    assign wr_hi[i]    = wr & (addr == OFS_VAL_HI[i]) & ~in_mode[i]; // RL7
    assign wr_lo[i]    = wr & (addr == OFS_VAL_LO[i]) & ~in_mode[i];
    assign rd_lo[i]    = rd & (addr == OFS_VAL_LO[i]);
    assign rd_hi_on[i] = req & ~apb_req.pwrite & (addr == OFS_VAL_HI[i]) & in_mode[i];
    assign wr_cfg[i]   = wr & (addr == OFS_CH_MODE[i]);
    assign ref_d[i]    = in_mode[i] ? 1'h0 : // RL20
                         (cfg_q[i].output_compare_mode == OCM_FORCE_HIGH) ? 1'h1 :
                         (cfg_q[i].output_compare_mode == OCM_FORCE_LOW) ? 1'h0 : ref_q[i];
    assign out_d[i]    = ~in_mode[i] & cfg_q[i].channel_enable_bit & // RL22
                         (ref_d[i] ^ cfg_q[i].channel_polarity);

    always_ff @(posedge clk_sys) begin
      if (!rstn) begin
        s1_q[i]   <= 1'h0;
        s2_q[i]   <= 1'h0;
        filt_q[i] <= 1'h0;
        fcnt_q[i] <= CNT3_ZERO;
        lvl_q[i]  <= 1'h0;
        pcnt_q[i] <= CNT3_ZERO;
        cfg_q[i]  <= CFG_RST;
        shd_q[i]  <= CNT_RST;
        pre_q[i]  <= CNT_RST;
        hold_q[i] <= 1'h0;
        frz_q[i]  <= 1'h0;
        ref_q[i]  <= 1'h0;
        out_q[i]  <= 1'h0;
      end else begin
        s1_q[i]  <= timer_input[i]; // RL9
        s2_q[i]  <= s1_q[i];
        lvl_q[i] <= lvl[i];
        ref_q[i] <= ref_d[i];
        out_q[i] <= out_d[i];
        if (s2_q[i] == filt_q[i]) begin // RL13
          fcnt_q[i] <= CNT3_ZERO;
        end else if (fcnt_q[i] == filt_limit(cfg_q[i].input_filter_setting)) begin
          filt_q[i] <= s2_q[i];
          fcnt_q[i] <= CNT3_ZERO;
        end else begin
          fcnt_q[i] <= fcnt_q[i] + CNT3_ONE;
        end
        if (edg[i] & cfg_q[i].channel_enable_bit) begin // RL15
          pcnt_q[i] <= psc_hit[i] ? CNT3_ZERO : pcnt_q[i] + CNT3_ONE;
        end
        if (wr_cfg[i]) begin
          cfg_q[i] <= ch_cfg_s'(apb_req.pwdata[$bits(ch_cfg_s)-1:0]);
        end
        if (latch[i]) begin // RL6
          shd_q[i] <= cnt_q;
        end else if (~in_mode[i] & ~hold_q[i]) begin // RL8
          shd_q[i] <= pre_q[i];
        end
        if (in_mode[i]) begin
          if (~frz_q[i] & ~rd_hi_on[i]) begin // RL23
            pre_q[i] <= shd_q[i];
          end
        end else begin
          if (wr_hi[i]) begin
            pre_q[i][15:8] <= wbyte;
          end
          if (wr_lo[i]) begin
            pre_q[i][7:0] <= wbyte;
          end
        end
        hold_q[i] <= wr_hi[i] | (hold_q[i] & ~wr_lo[i] & ~in_mode[i]); // RL8
        frz_q[i]  <= rd_hi_on[i] | (frz_q[i] & ~rd_lo[i] & in_mode[i]); // RL7
      end
    end
  end

  assign prdata                   = prdata_q;
  assign pready                   = pready_q;
  assign pslverr                  = pslverr_q;
  assign trigger_out              = trig_out_q;
  assign irq_request              = irq_q;
  assign compare_reference_signal = ref_q;
  assign compare_out              = out_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  property p_trig_out;
    $past(master_trigger_source_select) == MMS_ENABLE && !$past(master_slave_sync_bit)
      |-> trigger_out == counter_enable_signal;
  endproperty
  a_trig_out: assert property (p_trig_out) // RL1
    else $error("Trigger output does not follow the counter enable.");

  property p_sync_start;
    master_slave_sync_bit && slave_mode_select == SMS_TRIGGER &&
      master_trigger_source_select == MMS_ENABLE && trg_evt && !counter_enable_signal
      |=> trigger_out && !counter_enable_signal ##1 counter_enable_signal;
  endproperty
  a_sync_start: assert property (p_sync_start) // RL2
    else $error("Master start is not delayed to meet the linked slave.");

  property p_int_trig;
    trigger_input_select == TS_INTERNAL && slave_mode_select == SMS_TRIGGER &&
      !master_slave_sync_bit && trigger_in && !trg_prev_q
      |=> counter_enable_signal && stat_q.trigger_flag;
  endproperty
  a_int_trig: assert property (p_int_trig) // RL3
    else $error("Internal trigger edge did not start the counter.");

  property p_capture;
    latch[0] |=> shd_q[0] == $past(cnt_q) && stat_q.channel_capture_flag[0];
  endproperty
  a_capture: assert property (p_capture) // RL10
    else $error("Capture did not latch the counter and set the flag.");

  property p_overcap;
    latch[0] && stat_q.channel_capture_flag[0] |=> stat_q.channel_overcapture_flag[0];
  endproperty
  a_overcap: assert property (p_overcap) // RL11
    else $error("Overcapture flag not set on repeated capture.");

  property p_lo_read;
    rd_lo[0] && in_mode[0] && !flag_set[0]
      |=> !stat_q.channel_capture_flag[0] && $stable(stat_q.channel_overcapture_flag[0]);
  endproperty
  a_lo_read: assert property (p_lo_read) // RL12
    else $error("Low byte read handled the flags wrongly.");

  property p_freeze;
    frz_q[0] && in_mode[0] |=> $stable(pre_q[0]);
  endproperty
  a_freeze: assert property (p_freeze) // RL7
    else $error("Preload changed during a two-byte read.");

  property p_hold;
    hold_q[0] && !in_mode[0] |=> $stable(shd_q[0]);
  endproperty
  a_hold: assert property (p_hold) // RL8
    else $error("Shadow updated before the low byte write.");

  property p_filter;
    $changed(filt_q[0]) && cfg_q[0].input_filter_setting == FILT_8 &&
      $past(cfg_q[0].input_filter_setting, 8) == FILT_8
      |-> $past(s2_q[0]) == filt_q[0] && $past(s2_q[0], 8) == filt_q[0];
  endproperty
  a_filter: assert property (p_filter) // RL13
    else $error("Filter accepted a level without eight equal samples.");

  property p_force;
    !in_mode[0] && cfg_q[0].output_compare_mode == OCM_FORCE_HIGH
      |=> compare_reference_signal[0];
  endproperty
  a_force: assert property (p_force) // RL20
    else $error("Forced high reference is not high.");

  property p_sw_evt;
    evt.channel_sw_event[0] |=> stat_q.channel_capture_flag[0] &&
      (irq_request || !$past(irq_en_q[0]));
  endproperty
  a_sw_evt: assert property (p_sw_evt) // RL19
    else $error("Software event did not raise capture flag and interrupt.");

  c_overcap:  cover property (latch[0] && stat_q.channel_capture_flag[0]);
  c_sync:     cover property (master_slave_sync_bit && start);
  c_pwm_in:   cover property (clr_cnt && latch[1]);
  c_force:    cover property (ref_q[0] && !in_mode[0] && match[0]);
endmodule : timer_cc_channels

//--- timer_link_partner.sv
`timescale 1ns/1ps
module timer_link_partner (
  input  wire logic       clk_sys,
  input  wire logic       trigger_out,
  output logic      [1:0] timer_input,
  output logic            trigger_in,
  output logic            slave_running
);
  logic trig_prev_q;

  initial begin
    timer_input   = 2'h0;
    trigger_in    = 1'b0;
    slave_running = 1'b0;
    trig_prev_q   = 1'b0;
  end

  // A linked slave timer takes the master trigger as its own input and starts on its rise.
  always @(posedge clk_sys) begin
    trig_prev_q <= trigger_out;
    if (trigger_out && !trig_prev_q) begin
      slave_running <= 1'b1;
    end
  end

  task automatic pin_pulse(input int ch, input int width);
    @(posedge clk_sys);
    timer_input[ch] <= 1'b1;
    repeat (width) @(posedge clk_sys);
    timer_input[ch] <= 1'b0;
  endtask : pin_pulse

  task automatic trigger_edge();
    @(posedge clk_sys);
    trigger_in <= 1'b1;
  endtask : trigger_edge
endmodule : timer_link_partner

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import timer_cc_pkg::*;
  logic                   clk_sys;
  logic                   rstn;
  apb_req_s               apb_req;
  logic            [31:0] prdata;
  logic                   pready;
  logic                   pslverr;
  logic             [1:0] timer_input;
  logic                   trigger_in;
  logic                   trigger_out;
  logic                   irq_request;
  logic             [1:0] compare_reference_signal;
  logic             [1:0] compare_out;
  logic                   slave_running;
  logic            [31:0] rd;
  logic                   err;
  int                     num_errors;
  int                     cmp_count;
  int                     cycles;

  timer_cc_channels dut (
    .clk_sys                  (clk_sys),
    .rstn                     (rstn),
    .apb_req                  (apb_req),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .timer_input              (timer_input),
    .trigger_in               (trigger_in),
    .trigger_out              (trigger_out),
    .irq_request              (irq_request),
    .compare_reference_signal (compare_reference_signal),
    .compare_out              (compare_out)
  );

  timer_link_partner partner (
    .clk_sys       (clk_sys),
    .trigger_out   (trigger_out),
    .timer_input   (timer_input),
    .trigger_in    (trigger_in),
    .slave_running (slave_running)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    apb_req <= '{paddr: a, pwrite: w, pwdata: d, psel: 1'b1, penable: 1'b0};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task automatic test_reset_and_unmapped();
    apb(OFS_CTRL, 1'b0, 32'h0);
    chk("ctrl", rd, 32'h0);
    apb(8'h30, 1'b0, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
  endtask : test_reset_and_unmapped

  task automatic test_capture();
    apb(OFS_COUNT, 1'b1, 32'h1234);
    apb(OFS_CH_MODE[0], 1'b1, 32'h20D);
    apb(OFS_CH_MODE[1], 1'b1, 32'h30E);
    apb(OFS_IRQ_EN, 1'b1, 32'h1);
    partner.pin_pulse(0, 5);
    repeat (20) @(posedge clk_sys);
    apb(OFS_STATUS, 1'b0, 32'h0);
    chk("short pulse", rd, 32'h0);
    partner.pin_pulse(0, 12);
    repeat (20) @(posedge clk_sys);
    apb(OFS_STATUS, 1'b0, 32'h0);
    chk("both captured", rd, 32'h6);
    chk("irq", {31'h0, irq_request}, 32'h1);
    partner.pin_pulse(0, 12);
    repeat (20) @(posedge clk_sys);
    apb(OFS_STATUS, 1'b0, 32'h0);
    chk("overcapture", rd, 32'h1E);
    apb(OFS_VAL_LO[0], 1'b1, 32'hFF);
    apb(OFS_VAL_HI[0], 1'b0, 32'h0);
    chk("val hi", rd, 32'h12);
    apb(OFS_VAL_LO[0], 1'b0, 32'h0);
    chk("val lo", rd, 32'h34);
    apb(OFS_VAL_LO[1], 1'b0, 32'h0);
    chk("neighbour lo", rd, 32'h34);
    apb(OFS_STATUS, 1'b0, 32'h0);
    chk("flags after read", rd, 32'h18);
    apb(OFS_STATUS, 1'b1, 32'h0);
    apb(OFS_EVENT, 1'b1, 32'h2);
    apb(OFS_STATUS, 1'b0, 32'h0);
    chk("sw event", rd, 32'h2);
    chk("sw irq", {31'h0, irq_request}, 32'h1);
  endtask : test_capture

  task automatic test_output();
    apb(OFS_CH_MODE[1], 1'b1, 32'h1600);
    apb(OFS_VAL_HI[1], 1'b1, 32'hAB);
    apb(OFS_VAL_LO[1], 1'b1, 32'hCD);
    apb(OFS_VAL_HI[1], 1'b0, 32'h0);
    chk("out hi", rd, 32'hAB);
    apb(OFS_VAL_LO[1], 1'b0, 32'h0);
    chk("out lo", rd, 32'hCD);
    chk("force hi ref", {31'h0, compare_reference_signal[1]}, 32'h1);
    chk("force hi pin", {31'h0, compare_out[1]}, 32'h1);
    apb(OFS_CH_MODE[1], 1'b1, 32'h1700);
    repeat (3) @(posedge clk_sys);
    chk("inv ref", {31'h0, compare_reference_signal[1]}, 32'h1);
    chk("inv pin", {31'h0, compare_out[1]}, 32'h0);
    apb(OFS_CH_MODE[1], 1'b1, 32'h1200);
    repeat (3) @(posedge clk_sys);
    chk("force lo ref", {31'h0, compare_reference_signal[1]}, 32'h0);
    chk("force lo pin", {31'h0, compare_out[1]}, 32'h0);
  endtask : test_output

  task automatic test_trigger();
    apb(OFS_STATUS, 1'b1, 32'h0);
    apb(OFS_CTRL, 1'b1, 32'h662);
    partner.trigger_edge();
    repeat (5) @(posedge clk_sys);
    chk("trig out", {31'h0, trigger_out}, 32'h1);
    chk("slave start", {31'h0, slave_running}, 32'h1);
    apb(OFS_CTRL, 1'b0, 32'h0);
    chk("started", rd, 32'h663);
    apb(OFS_STATUS, 1'b0, 32'h0);
    chk("trig flag", rd[0], 1'b1);
    apb(OFS_COUNT, 1'b1, 32'hABC0);
    repeat (20) @(posedge clk_sys);
    apb(OFS_STATUS, 1'b0, 32'h0);
    chk("forced match flag", rd[2], 1'b1);
    chk("forced ref", {31'h0, compare_reference_signal[1]}, 32'h0);
  endtask : test_trigger

  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    num_errors = 0;
    cmp_count  = 0;
    cycles     = 0;
    rstn       = 1'b0;
    apb_req    = '0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    test_reset_and_unmapped();
    test_capture();
    test_output();
    test_trigger();
    report_and_stop();
  end
endmodule : tb_top
